// ---- rtl/adcsc_pkg.sv ----
// shared constants and types of the converter serial control block
//==================================================================
package adcsc_pkg;
  //================================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 2500;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);

  //================================================================
  // widths and counts
  localparam int RES_W = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CMD_BITS = 5'h08;
  localparam logic [CNT_W-1:0] LEN_LATCH_RISE = 5'h06;
  localparam logic [CNT_W-1:0] SAMPLE_FALL = 5'h04;
  localparam logic [CNT_W-1:0] BITS_8 = 5'h08;
  localparam logic [CNT_W-1:0] BITS_12 = 5'h0C;
  localparam logic [CNT_W-1:0] BITS_16 = 5'h10;
  localparam logic [5:0] PAD_BITS = 6'h04;
  localparam logic [5:0] LSB_BASE_8 = 6'h00;
  localparam logic [5:0] LSB_BASE_12 = 6'h04;
  localparam logic [5:0] LSB_BASE_16 = 6'h08;
  localparam logic [5:0] RES_TOP = 6'h0B;
  localparam int BUF_DEPTH = 2;

  //================================================================
  // configuration field layout and codes
  localparam int CFG_LEN_HI = 3;
  localparam int CFG_LEN_LO = 2;
  localparam int CFG_ORDER = 1;
  localparam int CFG_CODE = 0;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [3:0] CMD_PWRDN = 4'hE;
  localparam logic [3:0] CMD_RSVD = 4'hF;

  typedef enum logic {ST_IDLE, ST_CONV} adcsc_state_t;
endpackage

// ---- rtl/adcsc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adcsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adcsc_sync_t;

  adcsc_sync_t r_q;
  adcsc_sync_t r_d;

  //================================================================
  // first stage feeds only the second stage
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= {RST, RST};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule

// ---- rtl/adcsc_buf.sv ----
// small result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcsc_buf #(
  parameter int W = 12,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } adcsc_buf_t;

  adcsc_buf_t b_q;
  adcsc_buf_t b_d;
  logic push;
  logic pop;

  //================================================================
  // pointer and count update
  always_comb begin
    b_d = b_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      b_d.mem[b_q.wr] = in_data;
      b_d.wr = (b_q.wr == LAST) ? '0 : PW'(b_q.wr + 1'b1);
    end
    if (pop) begin
      b_d.rd = (b_q.rd == LAST) ? '0 : PW'(b_q.rd + 1'b1);
    end
    if (push && !pop) begin
      b_d.cnt = CW'(b_q.cnt + 1'b1);
    end else if (pop && !push) begin
      b_d.cnt = CW'(b_q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign in_ready = (b_q.cnt != FULL);
  assign out_valid = (b_q.cnt != '0);
  assign out_data = b_q.mem[b_q.rd];
endmodule

// ---- rtl/adcsc_top.sv ----
// serial command, configuration and result output of the converter
`timescale 1ns/1ps
module adcsc_top
  import adcsc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // serial link pins
  input wire logic CS_N,
  input wire logic IO_CLK,
  input wire logic DATA_IN,
  output logic DATA_OUT,
  output logic DATA_OUT_OE,
  output logic EOC,
  // analog core
  input wire logic [adcsc_pkg::RES_W-1:0] ADC_RESULT,
  output logic [3:0] ANALOG_SEL,
  output logic SAMPLE_EN,
  output logic POWER_DOWN
);
  import adcsc_pkg::*;

  typedef struct packed {
    adcsc_state_t st;
    logic io_prev;
    logic [CNT_W-1:0] rise_cnt;
    logic [CNT_W-1:0] fall_cnt;
    logic [7:0] serial_input_byte;
    logic [3:0] output_format_config;
    logic [3:0] command_nibble;
    logic [1:0] len;
    logic pwr_dn;
    logic sample;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic [RES_W-1:0] out_word;
    logic dout;
    logic oe;
  } adcsc_regs_t;

  adcsc_regs_t r_q;
  adcsc_regs_t r_d;

  logic cs_n_s;
  logic io_clk_s;
  logic din_s;
  logic rise;
  logic fall;
  logic push_valid;
  logic push_ready;
  logic pop_ready;
  logic buf_valid;
  logic [RES_W-1:0] buf_data;
  logic [RES_W-1:0] coded;
  logic [3:0] nib;
  logic [3:0] nib4;

  //================================================================
  // pin synchronisers; select idles high so it resets high
  adcsc_sync #(
    .W(3),
    .RST(3'h4)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d({CS_N, IO_CLK, DATA_IN}),
    .q({cs_n_s, io_clk_s, din_s})
  );

  //================================================================
  // finished results wait here until the output stage is free
  adcsc_buf #(
    .W(RES_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(MCLK),
    .rst_n(RESET_N),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(coded),
    .out_valid(buf_valid),
    .out_ready(pop_ready),
    .out_data(buf_data)
  );

  //================================================================
  // helpers
  function automatic logic [CNT_W-1:0] len_bits(input logic [1:0] len);
    logic [CNT_W-1:0] b;
    b = BITS_12;
    unique case (len)
      LEN_8: b = BITS_8;
      LEN_16: b = BITS_16;
      default: b = BITS_12;
    endcase
    return b;
  endfunction

  // k counts bits already advanced; out of range positions are pad zeros
  function automatic logic out_bit(
    input logic [RES_W-1:0] w,
    input logic [CNT_W-1:0] k,
    input logic [1:0] len,
    input logic lsb_first
  );
    logic [5:0] kk;
    logic [5:0] idx;
    logic [5:0] base;
    logic b;
    kk = {1'b0, k};
    idx = 6'h00;
    b = 1'b0;
    if (!lsb_first) begin
      if (kk <= RES_TOP) begin
        idx = RES_TOP - kk;
        b = w[idx[3:0]];
      end
    end else begin
      unique case (len)
        LEN_8: base = LSB_BASE_8;
        LEN_16: base = LSB_BASE_16;
        default: base = LSB_BASE_12;
      endcase
      idx = kk + PAD_BITS;
      if (idx >= base && (idx - base) <= RES_TOP) begin
        idx = idx - base;
        b = w[idx[3:0]];
      end
    end
    return b;
  endfunction

  //================================================================
  // result coding from the configuration in force for this conversion
  always_comb begin
    coded = ADC_RESULT;
    if (r_q.output_format_config[CFG_CODE]) begin
      coded[RES_W-1] = ~ADC_RESULT[RES_W-1];
    end
  end

  //================================================================
  // next state
  always_comb begin
    r_d = r_q;
    rise = io_clk_s && !r_q.io_prev;
    fall = !io_clk_s && r_q.io_prev;
    r_d.io_prev = io_clk_s;
    push_valid = 1'b0;
    pop_ready = 1'b0;
    nib = r_q.serial_input_byte[7:4];
    nib4 = r_q.serial_input_byte[3:0];
    if (cs_n_s) begin
      // deselect aborts any transfer or conversion and re-arms the cycle
      r_d.st = ST_IDLE;
      r_d.rise_cnt = '0;
      r_d.fall_cnt = '0;
      r_d.sample = 1'b0;
      r_d.conv_cnt = '0;
      r_d.len = r_q.output_format_config[CFG_LEN_HI:CFG_LEN_LO];
    end else begin
      unique case (r_q.st)
        ST_IDLE: begin
          pop_ready = (r_q.rise_cnt == '0) && (r_q.fall_cnt == '0);
          if (pop_ready) begin
            r_d.len = r_q.output_format_config[CFG_LEN_HI:CFG_LEN_LO];
            if (buf_valid) begin
              r_d.out_word = buf_data;
            end
          end
          if (rise && r_q.rise_cnt < CMD_BITS) begin
            r_d.serial_input_byte = {r_q.serial_input_byte[6:0], din_s};
            r_d.rise_cnt = CNT_W'(r_q.rise_cnt + 1'b1);
            if (r_d.rise_cnt == LEN_LATCH_RISE &&
                r_d.serial_input_byte[5:2] != CMD_RSVD) begin
              r_d.len = r_d.serial_input_byte[1:0];
            end
          end
          if (fall) begin
            r_d.fall_cnt = CNT_W'(r_q.fall_cnt + 1'b1);
            if (r_d.fall_cnt == SAMPLE_FALL) begin
              if (nib4 == CMD_PWRDN) begin
                r_d.pwr_dn = 1'b1;
              end
              r_d.sample = (nib4 != CMD_PWRDN) && (nib4 != CMD_RSVD);
            end
            if (r_d.fall_cnt == len_bits(r_q.len)) begin
              // last falling edge closes the I/O cycle
              r_d.sample = 1'b0;
              r_d.rise_cnt = '0;
              r_d.fall_cnt = '0;
              if (nib != CMD_RSVD) begin
                r_d.output_format_config = r_q.serial_input_byte[3:0];
                r_d.command_nibble = nib;
              end
              if (nib != CMD_PWRDN && nib != CMD_RSVD) begin
                r_d.pwr_dn = 1'b0;
                r_d.st = ST_CONV;
                r_d.conv_cnt = '0;
              end
            end
          end
        end
        ST_CONV: begin
          // the internal oscillator is modelled by a fixed cycle count
          if (r_q.conv_cnt != CONV_CNT_W'(CONV_CYCLES - 1)) begin
            r_d.conv_cnt = CONV_CNT_W'(r_q.conv_cnt + 1'b1);
          end else begin
            push_valid = 1'b1;
            if (push_ready) begin
              r_d.st = ST_IDLE;
            end
          end
        end
      endcase
    end
    // output forced low while converting, else the bit at the current index
    if (r_d.st == ST_CONV) begin
      r_d.dout = 1'b0;
    end else begin
      r_d.dout = out_bit(r_d.out_word, r_d.fall_cnt, r_d.len,
                         r_d.output_format_config[CFG_ORDER]);
    end
    r_d.oe = !cs_n_s;
  end

  //================================================================
  // state register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_q <= '{st: ST_IDLE, io_prev: 1'b0, rise_cnt: '0, fall_cnt: '0,
               serial_input_byte: '0, output_format_config: CFG_RESET,
               command_nibble: '0, len: '0, pwr_dn: 1'b1, sample: 1'b0,
               conv_cnt: '0, out_word: '0, dout: 1'b0, oe: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  //================================================================
  // outputs
  assign DATA_OUT = r_q.dout;
  assign DATA_OUT_OE = r_q.oe;
  assign EOC = (r_q.st != ST_CONV);
  assign ANALOG_SEL = r_q.command_nibble;
  assign SAMPLE_EN = r_q.sample;
  assign POWER_DOWN = r_q.pwr_dn;
endmodule

// ---- bench/adcsc_sva.sv ----
// pin-level assertions of the converter serial control block
`timescale 1ns/1ps
module adcsc_sva
  import adcsc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // pins
  input wire logic CS_N,
  input wire logic DATA_OUT,
  input wire logic DATA_OUT_OE,
  input wire logic EOC,
  input wire logic [3:0] ANALOG_SEL,
  input wire logic SAMPLE_EN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  //================================================================
  // conversion length counter; eight bits hold the whole conversion
  logic [7:0] low_cnt_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) low_cnt_q <= 8'h00;
    else if (EOC) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_q + 8'h01;
  end
  eoc_reset_a: assert property (disable iff (1'b0) !RESET_N |-> EOC)
    else $error("conversion-done low in reset");
  oe_off_a: assert property (CS_N [*4] |-> !DATA_OUT_OE)
    else $error("output still driven with select high");
  oe_on_a: assert property ($fell(CS_N) |-> ##[2:4] DATA_OUT_OE)
    else $error("output not driven after select fell");
  dout_zero_a: assert property (!EOC |-> !DATA_OUT)
    else $error("serial output not low while converting");
  sample_eoc_a: assert property (SAMPLE_EN |-> EOC)
    else $error("conversion-done low while sampling");
  eoc_fall_a: assert property ($fell(EOC) |-> $past(SAMPLE_EN))
    else $error("conversion-done fell without sampling");
  conv_len_a: assert property ($rose(EOC) |-> low_cnt_q >= 8'(CONV_CYCLES)
    && low_cnt_q <= 8'(CONV_CYCLES + 1))
    else $error("conversion time wrong");
  conv_max_a: assert property (!EOC |-> low_cnt_q <= 8'(CONV_CYCLES + 1))
    else $error("conversion never ends");
  sel_stable_a: assert property (!EOC && !$past(EOC) |-> $stable(ANALOG_SEL))
    else $error("input select moved during conversion");
endmodule
bind adcsc_top adcsc_sva adcsc_sva_i (
  .MCLK(MCLK),
  .RESET_N(RESET_N),
  .CS_N(CS_N),
  .DATA_OUT(DATA_OUT),
  .DATA_OUT_OE(DATA_OUT_OE),
  .EOC(EOC),
  .ANALOG_SEL(ANALOG_SEL),
  .SAMPLE_EN(SAMPLE_EN)
);

// ---- bench/adcsc_host.sv ----
// host serial master model driving the converter link pins
`timescale 1ns/1ps
module adcsc_host (
  // link pins driven
  output logic cs_n,
  output logic io_clk,
  output logic data_in,
  // link pins observed
  input wire logic data_out,
  input wire logic data_out_oe
);
  initial begin
    cs_n = 1'b1;
    io_clk = 1'b0;
    data_in = 1'b0;
  end
  //================================================================
  // one I/O cycle; clock stands low outside frames
  task automatic xfer(input logic [7:0] cmd, input bit tog, output logic [15:0] rx);
    int n;
    n = (cmd[3:2] == 2'h1) ? 8 : (cmd[3:2] == 2'h3) ? 16 : 12;
    rx = 16'h0000;
    if (tog) begin
      cs_n = 1'b1;
      #200;
    end
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      // past the byte the line toggles, since the device ignores it
      data_in = (i < 8) ? cmd[7-i] : ~data_in;
      #100 io_clk = 1'b1;
      #95 rx = {rx[14:0], data_out_oe ? data_out : 1'bx};
      #5 io_clk = 1'b0;
    end
  endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench of the converter serial control block
`timescale 1ns/1ps
module testbench;
  import adcsc_pkg::*;
  logic MCLK;
  logic RESET_N;
  logic [RES_W-1:0] ADC_RESULT;
  wire CS_N, IO_CLK, DATA_IN, DATA_OUT, DATA_OUT_OE, EOC, SAMPLE_EN, POWER_DOWN;
  wire [3:0] ANALOG_SEL;
  int n_fail = 0;
  int checks = 0;
  adcsc_top adcsc_top_i (.MCLK(MCLK), .RESET_N(RESET_N), .CS_N(CS_N), .IO_CLK(IO_CLK),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OUT_OE(DATA_OUT_OE), .EOC(EOC),
    .ADC_RESULT(ADC_RESULT), .ANALOG_SEL(ANALOG_SEL), .SAMPLE_EN(SAMPLE_EN),
    .POWER_DOWN(POWER_DOWN));
  adcsc_host adcsc_host_i (.cs_n(CS_N), .io_clk(IO_CLK), .data_in(DATA_IN),
    .data_out(DATA_OUT), .data_out_oe(DATA_OUT_OE));
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  //================================================================
  // shared helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // serial word as shifted: coding and order from the previous command
  function automatic logic [15:0] expect_word(input logic [11:0] r, input logic [3:0] pc,
    input logic [1:0] ln);
    logic [15:0] v;
    logic [15:0] w;
    int n;
    r[11] = r[11] ^ pc[0];
    n = (ln == 2'h1) ? 8 : (ln == 2'h3) ? 16 : 12;
    v = (n == 8) ? {8'h00, r[11:4]} : (n == 16) ? {r, 4'h0} : {4'h0, r};
    w = v;
    if (pc[1]) for (int i = 0; i < n; i++) w[i] = v[n-1-i];
    return w;
  endfunction
  task automatic wait_eoc;
    int k;
    k = 0;
    while (EOC !== 1'b1 && k < 300) begin
      @(posedge MCLK);
      k++;
    end
    check({15'h0000, EOC}, 16'h0001);
  endtask
  //================================================================
  // scenarios
  task automatic reset_state;
    check({13'h0000, EOC, DATA_OUT_OE, POWER_DOWN}, 16'h0005);
  endtask
  // lengths, orders and codings back to back; rows 6 and 7 convert nothing
  // rows 7 and 8 replay the stored word, so a config loaded by 1111 would flip its order
  task automatic format_table;
    logic [7:0] cmd [12] = '{8'h00, 8'h1D, 8'h26, 8'h47, 8'hB5, 8'hCB, 8'hEB, 8'hF0,
      8'hD3, 8'hA2, 8'h90, 8'h0C};
    logic [11:0] res [12] = '{12'h800, 12'hFFF, 12'h1E7, 12'h9B4, 12'h0F0, 12'h123,
      12'h000, 12'h000, 12'h456, 12'h789, 12'hABC, 12'h000};
    logic [11:0] tog = 12'h5A5;
    logic [11:0] chk = 12'hFFE;
    logic [3:0] pc = 4'h0;
    logic [11:0] pr = 12'h000;
    logic [15:0] rx;
    for (int i = 0; i < 12; i++) begin
      @(posedge MCLK);
      #1 ADC_RESULT = res[i];
      adcsc_host_i.xfer(cmd[i], tog[i], rx);
      if (chk[i]) check(rx, expect_word(pr, pc, cmd[i][3:2]));
      repeat (8) @(posedge MCLK);
      #1;
      if (cmd[i][7:5] == 3'h7) check({14'h0000, EOC, POWER_DOWN | cmd[i][4]}, 16'h0003);
      else begin
        check({10'h000, EOC, ANALOG_SEL, POWER_DOWN}, {10'h000, 1'b0, cmd[i][7:4], 1'b0});
        pc = cmd[i][3:0];
        pr = res[i];
      end
      wait_eoc;
      repeat (4) @(posedge MCLK);
    end
  endtask
  initial begin
    #1000000;
    n_fail++;
    close_out;
  end
  initial begin
    RESET_N = 1'b0;
    ADC_RESULT = 12'h000;
    repeat (2) @(posedge MCLK);
    reset_state;
    #1 RESET_N = 1'b1;
    repeat (2) @(posedge MCLK);
    format_table;
    close_out;
  end
endmodule
